// [logic/host_port_defs.vh]
// constants for the byte-wide host command port
// assumes a 125 MHz core clock and a 4-bit host i/o offset
`ifndef HOST_PORT_DEFS_VH
`define HOST_PORT_DEFS_VH
// ====================
// host i/o offsets
`define A_RDATA      4'h0
`define A_STATUS     4'h1
`define A_WDATA      4'h2
`define A_HWCTL      4'h3
`define A_RESET      4'h4
`define A_DOORBELL   4'h5
`define A_IRQ_ACK    4'h6
`define A_AUDIO      4'hb
// ====================
// status bit positions
`define ST_IRQ_N     3
`define ST_RD_FULL   6
`define ST_WR_FULL   7
// ====================
// hardware control fields and reset values
`define HW_AGC_OFF   1
`define HW_IRQ_TRI   3
`define HW_IRQ_MASK  4
`define HWCTL_RST    8'h00
`define AUDIO_RST    4'h0
// ====================
// command byte values
`define CMD_NOP      8'h00
`define CMD_START    8'h01
`define CMD_ABORT    8'h02
// ====================
// reason for interrupt codes
`define RSN_DONE     8'h00
`define RSN_TERM     8'h1c
`define RSN_STAT     8'h1d
`define RSN_READ     8'h1e
`define RSN_WRITE    8'h1f
// ====================
// record framing
`define REC_MAX      10'h200
`define REC_MIN      10'h002
`define REC_HDR      10'h002
`endif

// [logic/voice_board_host_command_port.v]
// host side i/o decode, data handshakes, reset and doorbell commands
// assumes host strobes are one-cycle pulses synchronous to clk and the
// board control processor sits on the cp_ ports
`timescale 1ns/1ps
`default_nettype none
`include "host_port_defs.vh"

// Function
// - bit 7 set on write, cleared on consume
// - bit 6 set on load, cleared by read
// - hard reset discards data, goes on-hook
// - commands: nop, start, abort
// - reason byte loaded before interrupt
// - reason codes 00, 1c to 1f
// - status record follows term or stat
// - start answered by write request reason
// - repeated read/write requests while running
// - words travel low byte first
// - length-prefixed records, at most 512 bytes
// - template lengths sent before templates
// - nonzero type byte soft, zero hard
// - acknowledge write clears latched interrupt
// - status bit 3 low while pending
module voice_board_host_command_port (
   input  wire       clk,
   input  wire       resetn,
   input  wire [3:0] host_addr,
   input  wire       host_wr,
   input  wire       host_rd,
   input  wire [7:0] host_wdata,
   output reg  [7:0] host_rdata,
   output reg        host_irq,
   output reg        host_irq_oe,
   output reg        cp_rx_valid,
   output reg  [7:0] cp_rx_data,
   input  wire       cp_rx_ready,
   output reg        wr_overrun,
   input  wire       cp_tx_valid,
   input  wire [7:0] cp_tx_data,
   input  wire       cp_tx_reason,
   output reg        cp_tx_ready,
   input  wire       cp_done,
   output reg        cmd_nop,
   output reg        cmd_start,
   output reg        cmd_abort,
   output reg        func_busy,
   output reg        soft_reset,
   output reg        hard_reset,
   output reg        line_onhook,
   output reg        agc_disable,
   output reg  [3:0] audio_path,
   output reg        rec_end,
   output reg        rec_len_err
);

// ====================
// host strobes
function hit;
   input [3:0] a;
   input [3:0] k;
   begin
      hit = (a == k);
   end
endfunction

wire wr_data  = host_wr & hit(host_addr, `A_WDATA);
wire wr_hwctl = host_wr & hit(host_addr, `A_HWCTL);
wire wr_reset = host_wr & hit(host_addr, `A_RESET);
wire wr_bell  = host_wr & hit(host_addr, `A_DOORBELL);
wire wr_ack   = host_wr & hit(host_addr, `A_IRQ_ACK);
wire wr_audio = host_wr & hit(host_addr, `A_AUDIO);
wire rd_data  = host_rd & hit(host_addr, `A_RDATA);
wire rd_stat  = host_rd & hit(host_addr, `A_STATUS);

reg [7:0] hwctl;
reg [7:0] last_byte;
reg [7:0] rd_reg;
reg       rd_full;
reg       irq_pend;
reg       irq_arm;
reg       v1;
reg [7:0] d1;

// ====================
// inbound two-entry buffer
// the newest host byte is also kept so a doorbell sees the command
// even after the control processor has drained it
wire pop   = cp_rx_valid & cp_rx_ready;
wire flush = wr_bell | (wr_reset & (last_byte == `CMD_NOP));
wire push  = wr_data & ~(v1 & ~pop);

always @(posedge clk or negedge resetn) begin
   if (!resetn) begin
      cp_rx_valid <= 1'b0;
      cp_rx_data  <= 8'h00;
      v1          <= 1'b0;
      d1          <= 8'h00;
      last_byte   <= 8'h00;
      wr_overrun  <= 1'b0;
   end else begin
      if (wr_data) begin
         last_byte <= host_wdata;
      end
      // a third byte with both slots full is lost and flagged
      wr_overrun <= wr_data & v1 & ~pop & ~flush;
      if (flush) begin
         cp_rx_valid <= 1'b0;
         v1          <= 1'b0;
      end else begin
         if (pop) begin
            if (v1) begin
               cp_rx_data <= d1;
               v1         <= push;
               d1         <= host_wdata;
            end else begin
               cp_rx_valid <= push;
               cp_rx_data  <= host_wdata;
            end
         end else if (push) begin
            if (cp_rx_valid) begin
               v1 <= 1'b1;
               d1 <= host_wdata;
            end else begin
               cp_rx_valid <= 1'b1;
               cp_rx_data  <= host_wdata;
            end
         end
      end
   end
end

// ====================
// outbound read data register and interrupt latch
wire load_rd = cp_tx_valid & cp_tx_ready;

always @(posedge clk or negedge resetn) begin
   if (!resetn) begin
      rd_reg      <= 8'h00;
      rd_full     <= 1'b0;
      cp_tx_ready <= 1'b1;
      irq_arm     <= 1'b0;
      irq_pend    <= 1'b0;
   end else begin
      if (hard_reset) begin
         rd_full     <= 1'b0;
         cp_tx_ready <= 1'b1;
         irq_arm     <= 1'b0;
         irq_pend    <= 1'b0;
      end else begin
         if (load_rd) begin
            rd_reg <= cp_tx_data;
         end
         rd_full     <= load_rd | (rd_full & ~rd_data);
         cp_tx_ready <= ~(load_rd | (rd_full & ~rd_data));
         // byte first, interrupt a cycle later
         irq_arm <= load_rd & cp_tx_reason;
         if (irq_arm) begin
            irq_pend <= 1'b1;
         end else if (wr_ack) begin
            irq_pend <= 1'b0;
         end
      end
   end
end

// ====================
// host read mux, registered; answer one cycle after the strobe
always @(posedge clk or negedge resetn) begin
   if (!resetn) begin
      host_rdata <= 8'h00;
   end else if (rd_data) begin
      host_rdata <= rd_reg;
   end else if (rd_stat) begin
      host_rdata <= 8'h00;
      host_rdata[`ST_WR_FULL] <= cp_rx_valid;
      host_rdata[`ST_RD_FULL] <= rd_full;
      host_rdata[`ST_IRQ_N] <= ~irq_pend;
   end
end

// ====================
// hardware and audio control, interrupt pin
always @(posedge clk or negedge resetn) begin
   if (!resetn) begin
      hwctl       <= `HWCTL_RST;
      audio_path  <= `AUDIO_RST;
      agc_disable <= 1'b0;
      host_irq    <= 1'b0;
      host_irq_oe <= 1'b1;
   end else begin
      if (wr_hwctl) begin
         hwctl       <= host_wdata;
         agc_disable <= host_wdata[`HW_AGC_OFF];
      end
      if (wr_audio) begin
         audio_path <= host_wdata[3:0];
      end
      // polling mode: pin floats, status bit 3 still works
      host_irq    <= irq_pend & ~hwctl[`HW_IRQ_MASK];
      host_irq_oe <= ~hwctl[`HW_IRQ_TRI];
   end
end

// ====================
// doorbell commands and programmed reset
always @(posedge clk or negedge resetn) begin
   if (!resetn) begin
      cmd_nop     <= 1'b0;
      cmd_start   <= 1'b0;
      cmd_abort   <= 1'b0;
      func_busy   <= 1'b0;
      soft_reset  <= 1'b0;
      hard_reset  <= 1'b0;
      line_onhook <= 1'b1;
   end else begin
      cmd_nop   <= wr_bell & (last_byte == `CMD_NOP);
      cmd_start <= wr_bell & (last_byte == `CMD_START);
      cmd_abort <= wr_bell & (last_byte == `CMD_ABORT);
      soft_reset <= wr_reset & (last_byte != `CMD_NOP);
      hard_reset <= wr_reset & (last_byte == `CMD_NOP);
      if (wr_reset & (last_byte == `CMD_NOP)) begin
         line_onhook <= 1'b1;
         func_busy   <= 1'b0;
      end else if (wr_bell & (last_byte == `CMD_START)) begin
         // running until the processor reports done, an abort command or a hard reset
         func_busy   <= 1'b1;
         line_onhook <= 1'b0;
      end else if ((wr_bell & (last_byte == `CMD_ABORT)) | cp_done) begin
         func_busy <= 1'b0;
      end
   end
end

// ====================
// record framing on the inbound stream
// low byte of the length first
reg [9:0] rec_cnt;
reg [9:0] rec_len;
reg       len_lo;
wire      in_rec  = (rec_cnt != 10'h000);
wire [9:0] cnt_nx = rec_cnt + 10'h001;

always @(posedge clk or negedge resetn) begin
   if (!resetn) begin
      rec_cnt     <= 10'h000;
      rec_len     <= 10'h000;
      len_lo      <= 1'b0;
      rec_end     <= 1'b0;
      rec_len_err <= 1'b0;
   end else begin
      rec_end     <= 1'b0;
      rec_len_err <= 1'b0;
      if (flush | hard_reset | ~func_busy) begin
         rec_cnt <= 10'h000;
         len_lo  <= 1'b0;
      end else if (pop) begin
         if (!in_rec && !len_lo) begin
            rec_len[7:0] <= cp_rx_data;
            len_lo       <= 1'b1;
         end else if (len_lo) begin
            len_lo <= 1'b0;
            // lengths outside 2..512 frame nothing
            if ({cp_rx_data, rec_len[7:0]} > {6'h00, `REC_MAX} ||
                {cp_rx_data, rec_len[7:0]} < {6'h00, `REC_MIN}) begin
               rec_len_err <= 1'b1;
            end else if ({cp_rx_data[1:0], rec_len[7:0]} == `REC_HDR) begin
               rec_end <= 1'b1;
            end else begin
               rec_len[9:8] <= cp_rx_data[1:0];
               rec_cnt      <= `REC_HDR;
            end
         end else if (cnt_nx == rec_len) begin
            rec_end <= 1'b1;
            rec_cnt <= 10'h000;
         end else begin
            rec_cnt <= cnt_nx;
         end
      end
   end
end

endmodule
`default_nettype wire

// [bench/host_port_props.sv]
// assertions on the pins of the host command port
// assumes one clock domain and a bind onto every port instance
`timescale 1ns/1ps
`default_nettype none
module host_port_props (
   input wire logic       clk,
   input wire logic       resetn,
   input wire logic [3:0] host_addr,
   input wire logic       host_wr,
   input wire logic       host_rd,
   input wire logic [7:0] host_rdata,
   input wire logic       host_irq,
   input wire logic       cp_rx_valid,
   input wire logic       cp_tx_valid,
   input wire logic       cp_tx_reason,
   input wire logic       cp_tx_ready,
   input wire logic       cmd_nop,
   input wire logic       cmd_start,
   input wire logic       cmd_abort,
   input wire logic       func_busy,
   input wire logic       soft_reset,
   input wire logic       hard_reset
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   wire take = cp_tx_valid && cp_tx_ready;
   // ====================
   // handshake and command checks
   a_wr_full_set: assert property (host_wr && host_addr == 4'h2 |=> cp_rx_valid)
      else $error("written byte not flagged");
   a_rd_full: assert property (take |=> !cp_tx_ready)
      else $error("read register not full");
   a_rd_clear: assert property (host_rd && host_addr == 4'h0 && !cp_tx_ready |=> cp_tx_ready)
      else $error("read did not empty register");
   a_status_bits: assert property (host_rd && host_addr == 4'h1 |=>
      host_rdata[7] == $past(cp_rx_valid) && host_rdata[6] == !$past(cp_tx_ready))
      else $error("status full bits wrong");
   // a reason taken one cycle earlier lands with the ack and wins
   a_ack_clear: assert property (host_wr && host_addr == 4'h6 && !$past(take && cp_tx_reason) |=> ##1 !host_irq)
      else $error("ack left interrupt set");
   a_reset_kind: assert property (host_wr && host_addr == 4'h4 |=> soft_reset != hard_reset)
      else $error("reset kind not single");
   a_start_busy: assert property (cmd_start |-> func_busy)
      else $error("start without busy");
   a_cmd_onehot: assert property ($onehot0({cmd_nop, cmd_start, cmd_abort}))
      else $error("several commands at once");
endmodule
bind voice_board_host_command_port host_port_props u_host_port_props (.clk, .resetn, .host_addr, .host_wr,
   .host_rd, .host_rdata, .host_irq, .cp_rx_valid, .cp_tx_valid, .cp_tx_reason, .cp_tx_ready, .cmd_nop,
   .cmd_start, .cmd_abort, .func_busy, .soft_reset, .hard_reset);
`default_nettype wire

// [bench/host_model.sv]
// host processor model: one-cycle read and write strobes
// assumes the port samples strobes on the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic       clk,
   output var  logic [3:0] host_addr,
   output var  logic       host_wr,
   output var  logic       host_rd,
   output var  logic [7:0] host_wdata,
   input  wire logic [7:0] host_rdata
);
   initial begin
      host_addr = 4'h0;
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_wdata = 8'h00;
   end
   // ====================
   // bus cycles
   // released data is inverted so a stale byte is never reused
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      host_addr <= a;
      host_wdata <= d;
      host_wr <= 1'b1;
      @(posedge clk);
      host_wr <= 1'b0;
      host_wdata <= ~d;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      host_addr <= a;
      host_rd <= 1'b1;
      @(posedge clk);
      host_rd <= 1'b0;
      #1;
      d = host_rdata;
   endtask
endmodule
`default_nettype wire

// [bench/voice_board_host_command_port_test.sv]
// self-checking bench for the host command port
// assumes host_model as the host and the bench as control processor
`timescale 1ns/1ps
`default_nettype none
module voice_board_host_command_port_test;
   logic       clk = 1'b0;
   logic       resetn = 1'b0;
   logic       cp_rx_ready = 1'b0;
   logic       cp_tx_valid = 1'b0;
   logic       cp_tx_reason = 1'b0;
   logic       cp_done = 1'b0;
   logic [7:0] cp_tx_data = 8'h00;
   logic [7:0] hits;
   logic [7:0] d;
   int         n_errors = 0;
   int         total_checks = 0;
   wire  [3:0] host_addr, audio_path;
   wire  [7:0] host_wdata, host_rdata, cp_rx_data;
   wire        host_wr, host_rd, host_irq, host_irq_oe, cp_rx_valid, wr_overrun, cp_tx_ready, cmd_nop;
   wire        cmd_start, cmd_abort, func_busy, soft_reset, hard_reset, line_onhook, agc_disable;
   wire        rec_end, rec_len_err;
   voice_board_host_command_port u_voice_board_host_command_port (.clk, .resetn, .host_addr, .host_wr,
      .host_rd, .host_wdata, .host_rdata, .host_irq, .host_irq_oe, .cp_rx_valid, .cp_rx_data, .cp_rx_ready,
      .wr_overrun, .cp_tx_valid, .cp_tx_data, .cp_tx_reason, .cp_tx_ready, .cp_done, .cmd_nop,
      .cmd_start, .cmd_abort, .func_busy, .soft_reset, .hard_reset, .line_onhook, .agc_disable,
      .audio_path, .rec_end, .rec_len_err);
   host_model u_host_model (.clk, .host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata);
   initial begin
      forever #4 clk = ~clk;
   end
   // ====================
   // shared tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // collects every pulse output, so a stray pulse fails too
   task automatic watch(input int n);
      hits = 8'h00;
      repeat (n) begin
         #1;
         hits = hits | {wr_overrun, rec_end, rec_len_err, hard_reset, soft_reset, cmd_abort, cmd_start, cmd_nop};
         @(posedge clk);
      end
   endtask
   task automatic seq(input logic [3:0] a, input logic [7:0] c, input logic [7:0] exp);
      u_host_model.wr(4'h2, c);
      u_host_model.wr(a, 8'h00);
      watch(2);
      chk(hits, exp);
   endtask
   task automatic pop();
      @(posedge clk);
      cp_rx_ready <= 1'b1;
      @(posedge clk);
      cp_rx_ready <= 1'b0;
      #1;
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ====================
   // scenarios
   // host ignores the full bit here on purpose to overrun the buffer
   task automatic s_buffer();
      u_host_model.wr(4'h2, 8'haa);
      u_host_model.rd(4'h1, d);
      chk(d, 8'h88);
      u_host_model.wr(4'h2, 8'hbb);
      u_host_model.wr(4'h2, 8'hcc);
      watch(3);
      chk(hits, 8'h80);
      chk(cp_rx_data, 8'haa);
      pop();
      chk(cp_rx_data, 8'hbb);
      pop();
      chk(cp_rx_valid, 1'b0);
   endtask
   task automatic s_reasons();
      logic [7:0] codes [5] = '{8'h1f, 8'h1e, 8'h1d, 8'h1c, 8'h00};
      foreach (codes[i]) begin
         @(posedge clk);
         cp_tx_valid <= 1'b1;
         cp_tx_reason <= 1'b1;
         cp_tx_data <= codes[i];
         @(posedge clk);
         cp_tx_valid <= 1'b0;
         cp_tx_data <= ~codes[i];
         repeat (3) @(posedge clk);
         #1;
         chk(host_irq, 1'b1);
         u_host_model.rd(4'h1, d);
         chk(d, 8'h40);
         u_host_model.rd(4'h0, d);
         chk(d, codes[i]);
         u_host_model.rd(4'h1, d);
         chk(d, 8'h00);
         u_host_model.wr(4'h6, 8'h00);
         @(posedge clk);
         #1;
         chk(host_irq, 1'b0);
      end
   endtask
   task automatic s_record();
      @(posedge clk);
      cp_rx_ready <= 1'b1;
      // template length record naming one six-byte template
      u_host_model.wr(4'h2, 8'h04);
      u_host_model.wr(4'h2, 8'h00);
      u_host_model.wr(4'h2, 8'h06);
      u_host_model.wr(4'h2, 8'h00);
      watch(4);
      chk(hits, 8'h40);
      // template: length, word id, template id
      u_host_model.wr(4'h2, 8'h06);
      u_host_model.wr(4'h2, 8'h00);
      u_host_model.wr(4'h2, 8'h01);
      u_host_model.wr(4'h2, 8'h00);
      u_host_model.wr(4'h2, 8'h02);
      u_host_model.wr(4'h2, 8'h00);
      watch(4);
      chk(hits, 8'h40);
      u_host_model.wr(4'h2, 8'h01);
      u_host_model.wr(4'h2, 8'h02);
      watch(4);
      chk(hits, 8'h20);
   endtask
   task automatic s_resets();
      u_host_model.wr(4'h3, 8'h1a);
      u_host_model.wr(4'hb, 8'h05);
      seq(4'h4, 8'h01, 8'h08);
      chk({agc_disable, host_irq_oe, line_onhook, audio_path}, 8'h45);
      seq(4'h4, 8'h00, 8'h10);
      chk(line_onhook, 1'b1);
      repeat (12500) @(posedge clk);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      #1;
      chk({cp_tx_ready, host_irq_oe, line_onhook, host_irq, cp_rx_valid, func_busy}, 8'h38);
      s_buffer();
      seq(4'h5, 8'h00, 8'h01);
      seq(4'h5, 8'h01, 8'h02);
      chk(func_busy, 1'b1);
      s_reasons();
      s_record();
      seq(4'h5, 8'h02, 8'h04);
      chk(func_busy, 1'b0);
      @(posedge clk);
      cp_rx_ready <= 1'b0;
      seq(4'h5, 8'h01, 8'h02);
      // the control processor reports the function finished
      @(posedge clk);
      cp_done <= 1'b1;
      @(posedge clk);
      cp_done <= 1'b0;
      @(posedge clk);
      #1;
      chk(func_busy, 1'b0);
      s_resets();
      final_report();
   end
   initial begin
      #800000;
      n_errors++;
      final_report();
   end
endmodule
`default_nettype wire
